// ===== pio_board.sv
// board model: resolves port b and c pin levels from both drivers
`timescale 1ns/1ps
module pio_board (
  // design drive
  input wire pio_pkg::pio_pb_pins_s pb_pins_i,
  input wire pio_pkg::pio_pc_pins_s pc_pins_i,
  // board levels on released pins
  input wire logic [11:0] pb_ext_i,
  input wire logic [7:0] pc_ext_i,
  // resolved levels
  output logic [11:0] pb_lvl_o,
  output logic [7:0] pc_lvl_o
);
  // board drivers are weak, so an enabled design driver always wins
  assign pb_lvl_o = (pb_pins_i.out & ~pb_pins_i.oe_n) | (pb_ext_i & pb_pins_i.oe_n);
  assign pc_lvl_o = (pc_pins_i.out & ~pc_pins_i.oe_n) | (pc_ext_i & pc_pins_i.oe_n);
endmodule

// ===== pio_pkg.sv
// package: register map, reset values and carriers for the parallel port block
package pio_pkg;

  // register byte addresses
  localparam logic [7:0] PIO_A_SEL_ADDR = 8'h00;
  localparam logic [7:0] PIO_A_DIR_ADDR = 8'h04;
  localparam logic [7:0] PIO_A_DAT_ADDR = 8'h08;
  localparam logic [7:0] PIO_B_SEL_ADDR = 8'h0C;
  localparam logic [7:0] PIO_B_DIR_ADDR = 8'h10;
  localparam logic [7:0] PIO_B_DAT_ADDR = 8'h14;
  localparam logic [7:0] PIO_C_DIR_ADDR = 8'h18;
  localparam logic [7:0] PIO_C_DAT_ADDR = 8'h1C;
  localparam logic [7:0] PIO_D_DAT_ADDR = 8'h20;
  localparam logic [7:0] PIO_SYS_CTRL_ADDR = 8'h24;
  localparam logic [7:0] PIO_GLB_MASK_ADDR = 8'h28;
  localparam logic [7:0] PIO_SRC_MASK_ADDR = 8'h2C;

  // field widths and masks
  localparam int PIO_A_W = 16;
  localparam int PIO_B_W = 12;
  localparam int PIO_BL_W = 8;
  localparam int PIO_BH_W = 4;
  localparam int PIO_C_W = 8;
  localparam int PIO_D_W = 16;
  localparam logic [15:0] PIO_B_SEL_MASK = 16'h00FF;
  localparam logic [15:0] PIO_B_MASK = 16'h0FFF;
  localparam logic [15:0] PIO_C_MASK = 16'h00FF;
  localparam int PIO_REFRESH_BIT = 0;
  localparam int PIO_GLB_EN_BIT = 0;
  localparam int PIO_PB_REFRESH_PIN = 8;
  localparam int PIO_PB_WATCHDOG_OUTPUT_PIN = 7;
  localparam int PIO_PB_TIMER1_INPUT_PIN = 3;
  localparam int PIO_PB_TIMER2_INPUT_PIN = 5;

  // reset values
  localparam logic [7:0] PIO_B_SEL_RST = 8'h80;
  localparam logic [11:0] PIO_B_DIR_RST = 12'h000;
  localparam logic [15:0] PIO_ZERO16 = 16'h0000;

  // low port b pins whose peripheral function drives the pin
  localparam logic [7:0] PIO_B_PER_OUT = 8'hD7;

  // ahb-lite codes
  localparam logic [1:0] PIO_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PIO_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] PIO_HSIZE_WORD = 3'h2;

  // peripheral signals toward the low port b pins
  typedef struct packed {
    logic watchdog_output;
    logic tmr2_out;
    logic tmr1_out;
    logic ack1;
    logic ack6;
    logic ack7;
  } pio_periph_s;

  // pin carrier: output level and active-low output enable
  typedef struct packed {
    logic [11:0] out;
    logic [11:0] oe_n;
  } pio_pb_pins_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pio_pc_pins_s;

endpackage

// ===== pio_ports.sv
// parallel i/o ports b, c, d with register file on an ahb-lite slave
`timescale 1ns/1ps
// What this block does
// R1 - port b has twelve pins: low eight selectable, upper four general-purpose with interrupts
// R2 - low port b pins behave like port a pins under port b registers
// R3 - after reset pin b7 is the open-drain watchdog output
// R4 - selected pins b0..b7 carry ack7, ack6, ack1, timer1_input, timer1_output, timer2_input, timer2_output, watchdog
// R5 - a timer input pin used as general-purpose feeds ground to the timer
// R6 - pin b8 becomes the refresh request pin when system control selects it
// R7 - port b direction 0 input, 1 output; reset clears bits 11..8
// R8 - reset clears the global interrupt mask
// R9 - port b data writes go to a latch which drives output pins and reads back
// R10 - for input pins writes only reach the latch; reads return the pin
// R11 - falling edge on an upper port b input pin raises an interrupt request
// R12 - four requests have fixed level-4 priority, each masked by its own bit
// R13 - port c pins exist only while the card interface enable pin is low
// R14 - port c direction 0 input, 1 output; reset clears all of them
// R15 - port c writes always latch, drive only output pins; reads latch or pin
// R16 - port d is sixteen inputs read as current levels when card interface off
// R17 - registers are 16-bit read/write with the documented field widths
// R18 - reserved bits read as zero
// R19 - select bit 0 is general-purpose, 1 is peripheral function
// R20 - peripheral pins ignore direction bit; data reads give peripheral pin state
// R21 - reset clears port a select and direction bits
// R22 - upper pins are synchronised before falling edge detection
module pio_ports (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // port b pins
  input wire logic [11:0] pb_pin_i,
  output pio_pkg::pio_pb_pins_s pb_pins_o,
  // port c and d pins
  input wire logic card_interface_enable_pin_i,
  input wire logic [7:0] pc_pin_i,
  output pio_pkg::pio_pc_pins_s pc_pins_o,
  input wire logic [15:0] pd_pin_i,
  // on-chip peripherals
  input wire pio_pkg::pio_periph_s periph_i,
  input wire logic refresh_req_i,
  output logic timer1_input_o,
  output logic timer2_input_o,
  // requests to the interrupt controller, bit 0 is pin b8
  output logic [3:0] pb_irq_req_o,
  // port a configuration for the port a pin logic
  output logic [15:0] port_a_select_bits_o,
  output logic [15:0] port_a_direction_bits_o,
  output logic [15:0] port_a_latch_o
);

  // register state
  logic [15:0] pa_sel_q;
  logic [15:0] pa_dir_q;
  logic [15:0] pa_dat_q;
  logic [7:0] pb_sel_q;
  logic [11:0] pb_dir_q;
  logic [11:0] pb_dat_q;
  logic [7:0] pc_dir_q;
  logic [7:0] pc_dat_q;
  logic sys_refresh_q;
  logic glb_en_q;
  logic [3:0] src_mask_q;

  // bus data phase
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rd_data_d;
  logic addr_ok;
  logic [7:0] a_addr;

  // edge detection
  logic [3:0] pbh_s1_q;
  logic [3:0] pbh_s2_q;
  logic [3:0] pbh_s3_q;
  logic [3:0] irq_d;

  // combined pin views
  logic [7:0] per_out;
  logic [7:0] pb_low_rd;
  logic [11:0] pb_rd;
  logic [7:0] pc_rd;
  logic [15:0] wdata;

  // read-back of a bidirectional bit: latch when driven, pin otherwise
  function automatic logic pio_rd_bit(input logic dir, input logic latch, input logic pin);
    pio_rd_bit = dir ? latch : pin;
  endfunction

  function automatic logic [31:0] pio_word(input logic [15:0] v);
    pio_word = {16'h0000, v};
  endfunction

  assign a_addr = haddr_i[7:0];
  assign wdata = hwdata_i[15:0];
  // only whole-word aligned transfers are decoded
  assign addr_ok = hsel_i && hready_i && htrans_i[1] && (hsize_i == pio_pkg::PIO_HSIZE_WORD)
                   && (haddr_i[31:8] == 24'h000000);

  // peripheral drive values for b0..b7
  assign per_out = {periph_i.watchdog_output, periph_i.tmr2_out, 1'b0, periph_i.tmr1_out, 1'b0,
                    periph_i.ack1, periph_i.ack6, periph_i.ack7}; // R4

  always_comb begin
    for (int i = 0; i < pio_pkg::PIO_BL_W; i++) begin
      if (pb_sel_q[i]) begin
        pb_low_rd[i] = pio_pkg::PIO_B_PER_OUT[i] ? per_out[i] : pb_pin_i[i]; // R20
      end else begin
        pb_low_rd[i] = pio_rd_bit(pb_dir_q[i], pb_dat_q[i], pb_pin_i[i]); // R2 R10
      end
    end
    for (int i = pio_pkg::PIO_BL_W; i < pio_pkg::PIO_B_W; i++) begin
      pb_rd[i] = pio_rd_bit(pb_dir_q[i], pb_dat_q[i], pb_pin_i[i]); // R9 R10
    end
    pb_rd[7:0] = pb_low_rd;
    for (int i = 0; i < pio_pkg::PIO_C_W; i++) begin
      pc_rd[i] = pio_rd_bit(pc_dir_q[i], pc_dat_q[i], pc_pin_i[i]); // R15
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_data_d = 32'h00000000;
    case (a_addr)
      pio_pkg::PIO_A_SEL_ADDR: rd_data_d = pio_word(pa_sel_q); // R17
      pio_pkg::PIO_A_DIR_ADDR: rd_data_d = pio_word(pa_dir_q);
      pio_pkg::PIO_A_DAT_ADDR: rd_data_d = pio_word(pa_dat_q);
      pio_pkg::PIO_B_SEL_ADDR: rd_data_d = pio_word({8'h00, pb_sel_q}); // R18
      pio_pkg::PIO_B_DIR_ADDR: rd_data_d = pio_word({4'h0, pb_dir_q});
      pio_pkg::PIO_B_DAT_ADDR: rd_data_d = pio_word({4'h0, pb_rd});
      pio_pkg::PIO_C_DIR_ADDR: rd_data_d = pio_word({8'h00, pc_dir_q});
      pio_pkg::PIO_C_DAT_ADDR: rd_data_d = pio_word({8'h00, pc_rd});
      pio_pkg::PIO_D_DAT_ADDR: begin
        // absent while the card interface owns the pins
        rd_data_d = card_interface_enable_pin_i ? 32'h00000000 : pio_word(pd_pin_i); // R16
      end
      pio_pkg::PIO_SYS_CTRL_ADDR: rd_data_d = pio_word({15'h0000, sys_refresh_q});
      pio_pkg::PIO_GLB_MASK_ADDR: rd_data_d = pio_word({15'h0000, glb_en_q});
      pio_pkg::PIO_SRC_MASK_ADDR: rd_data_d = pio_word({12'h000, src_mask_q});
      default: rd_data_d = 32'h00000000;
    endcase
  end

  // bus handshake: zero wait states, always okay
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend_q <= addr_ok && hwrite_i;
      if (addr_ok) begin
        wr_addr_q <= a_addr;
      end
      // read data sampled in the address phase; a write still in its data phase is not yet visible
      if (addr_ok && !hwrite_i) begin
        hrdata_o <= rd_data_d;
      end
    end
  end

  // port a registers
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pa_sel_q <= pio_pkg::PIO_ZERO16; // R21
      pa_dir_q <= pio_pkg::PIO_ZERO16; // R21
      pa_dat_q <= pio_pkg::PIO_ZERO16;
    end else if (wr_pend_q) begin
      if (wr_addr_q == pio_pkg::PIO_A_SEL_ADDR) pa_sel_q <= wdata; // R19
      if (wr_addr_q == pio_pkg::PIO_A_DIR_ADDR) pa_dir_q <= wdata;
      if (wr_addr_q == pio_pkg::PIO_A_DAT_ADDR) pa_dat_q <= wdata;
    end
  end

  // port b and c registers
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pb_sel_q <= pio_pkg::PIO_B_SEL_RST; // R3
      pb_dir_q <= pio_pkg::PIO_B_DIR_RST; // R7
      pb_dat_q <= 12'h000;
      pc_dir_q <= 8'h00; // R14
      pc_dat_q <= 8'h00;
    end else if (wr_pend_q) begin
      if (wr_addr_q == pio_pkg::PIO_B_SEL_ADDR) pb_sel_q <= wdata[7:0]; // R19
      if (wr_addr_q == pio_pkg::PIO_B_DIR_ADDR) pb_dir_q <= wdata[11:0]; // R7
      if (wr_addr_q == pio_pkg::PIO_B_DAT_ADDR) pb_dat_q <= wdata[11:0]; // R9
      if (wr_addr_q == pio_pkg::PIO_C_DIR_ADDR) pc_dir_q <= wdata[7:0]; // R14
      if (wr_addr_q == pio_pkg::PIO_C_DAT_ADDR) pc_dat_q <= wdata[7:0]; // R15
    end
  end

  // system control and interrupt masks
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_refresh_q <= 1'b0;
      glb_en_q <= 1'b0; // R8
      src_mask_q <= 4'h0;
    end else if (wr_pend_q) begin
      if (wr_addr_q == pio_pkg::PIO_SYS_CTRL_ADDR) sys_refresh_q <= wdata[pio_pkg::PIO_REFRESH_BIT];
      if (wr_addr_q == pio_pkg::PIO_GLB_MASK_ADDR) glb_en_q <= wdata[pio_pkg::PIO_GLB_EN_BIT];
      if (wr_addr_q == pio_pkg::PIO_SRC_MASK_ADDR) src_mask_q <= wdata[3:0]; // R12
    end
  end

  // port b pin drivers
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pb_pins_o.out <= 12'h000;
      pb_pins_o.oe_n <= 12'hFFF;
    end else begin
      for (int i = 0; i < pio_pkg::PIO_BL_W; i++) begin
        if (pb_sel_q[i]) begin
          // peripheral sets direction, direction bit ignored
          pb_pins_o.out[i] <= per_out[i]; // R4 R20
          pb_pins_o.oe_n[i] <= !pio_pkg::PIO_B_PER_OUT[i];
        end else begin
          pb_pins_o.out[i] <= pb_dat_q[i]; // R2
          pb_pins_o.oe_n[i] <= !pb_dir_q[i];
        end
      end
      // watchdog is open drain: drive low only
      if (pb_sel_q[pio_pkg::PIO_PB_WATCHDOG_OUTPUT_PIN]) begin
        pb_pins_o.out[pio_pkg::PIO_PB_WATCHDOG_OUTPUT_PIN] <= 1'b0; // R3
        pb_pins_o.oe_n[pio_pkg::PIO_PB_WATCHDOG_OUTPUT_PIN] <= periph_i.watchdog_output; // R3
      end
      for (int i = pio_pkg::PIO_BL_W; i < pio_pkg::PIO_B_W; i++) begin
        pb_pins_o.out[i] <= pb_dat_q[i]; // R9
        pb_pins_o.oe_n[i] <= !pb_dir_q[i]; // R7 R10
      end
      if (sys_refresh_q) begin
        pb_pins_o.out[pio_pkg::PIO_PB_REFRESH_PIN] <= refresh_req_i; // R6
        pb_pins_o.oe_n[pio_pkg::PIO_PB_REFRESH_PIN] <= 1'b0; // R6
      end
    end
  end

  // timer inputs, grounded when the pin is general-purpose
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer1_input_o <= 1'b0;
      timer2_input_o <= 1'b0;
    end else begin
      timer1_input_o <= pb_sel_q[pio_pkg::PIO_PB_TIMER1_INPUT_PIN] & pb_pin_i[pio_pkg::PIO_PB_TIMER1_INPUT_PIN]; // R5
      timer2_input_o <= pb_sel_q[pio_pkg::PIO_PB_TIMER2_INPUT_PIN] & pb_pin_i[pio_pkg::PIO_PB_TIMER2_INPUT_PIN]; // R5
    end
  end

  // port c pins, released while the card interface owns them
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_pins_o.out <= 8'h00;
      pc_pins_o.oe_n <= 8'hFF;
    end else begin
      pc_pins_o.out <= pc_dat_q; // R15
      pc_pins_o.oe_n <= card_interface_enable_pin_i ? 8'hFF : ~pc_dir_q; // R13
    end
  end

  // synchronise upper pins; stage one feeds stage two only
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pbh_s1_q <= 4'hF;
      pbh_s2_q <= 4'hF;
      pbh_s3_q <= 4'hF;
    end else begin
      pbh_s1_q <= pb_pin_i[11:8]; // R22
      pbh_s2_q <= pbh_s1_q; // R22
      pbh_s3_q <= pbh_s2_q;
    end
  end

  // falling edge on an input pin, one pulse per edge
  always_comb begin
    irq_d = pbh_s3_q & ~pbh_s2_q & ~pb_dir_q[11:8]; // R11
    irq_d[0] = irq_d[0] & !sys_refresh_q; // R6
    irq_d = irq_d & src_mask_q & {4{glb_en_q}}; // R12 R8
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pb_irq_req_o <= 4'h0;
    end else begin
      pb_irq_req_o <= irq_d; // R1 R11
    end
  end

  // port a configuration out
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_a_select_bits_o <= pio_pkg::PIO_ZERO16;
      port_a_direction_bits_o <= pio_pkg::PIO_ZERO16;
      port_a_latch_o <= pio_pkg::PIO_ZERO16;
    end else begin
      port_a_select_bits_o <= pa_sel_q;
      port_a_direction_bits_o <= pa_dir_q;
      port_a_latch_o <= pa_dat_q;
    end
  end

endmodule

// ===== pio_ports_monitor.sv
// checker: port-level assertions for the parallel port block
`timescale 1ns/1ps
module pio_ports_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // bus side
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  // pin side
  input wire logic [11:0] pb_pin_i,
  input wire pio_pkg::pio_pb_pins_s pb_pins_o,
  input wire logic card_interface_enable_pin_i,
  input wire pio_pkg::pio_pc_pins_s pc_pins_o,
  input wire pio_pkg::pio_periph_s periph_i,
  input wire logic timer1_input_o,
  input wire logic timer2_input_o,
  input wire logic [3:0] pb_irq_req_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // first edge whose sampled pins show the post-reset configuration
  sequence just_released;
    !$past(nrst_i, 2) && $past(nrst_i);
  endsequence
  hresp_okay_a: assert property (!hresp_o) else $error("bus response not okay");
  rdata_upper_a: assert property (hrdata_o[31:16] == 16'h0000) else $error("read data upper half set");
  hready_high_a: assert property ($past(nrst_i) |-> hreadyout_o) else $error("bus stalled");
  watchdog_output_reset_a: assert property (just_released |-> pb_pins_o.out[7] == 1'b0 &&
    pb_pins_o.oe_n[7] == $past(periph_i.watchdog_output)) else $error("pin b7 not open-drain watchdog");
  inputs_reset_a: assert property (just_released |-> pb_pins_o.oe_n[11:8] == 4'hF &&
    pc_pins_o.oe_n == 8'hFF) else $error("pins not inputs after reset");
  irq_once_a: assert property (pb_irq_req_o != 4'h0 |=> (pb_irq_req_o & $past(pb_irq_req_o)) == 4'h0)
    else $error("request longer than one cycle");
  irq_input_a: assert property ((pb_irq_req_o & ~pb_pins_o.oe_n[11:8]) == 4'h0)
    else $error("request from an output pin");
  tmr1_pin_a: assert property (timer1_input_o |-> $past(pb_pin_i[3])) else $error("timer1 input not pin");
  tmr2_pin_a: assert property (timer2_input_o |-> $past(pb_pin_i[5])) else $error("timer2 input not pin");
  card_off_a: assert property ($past(card_interface_enable_pin_i) |-> pc_pins_o.oe_n == 8'hFF)
    else $error("port c driven with card interface on");
endmodule
bind pio_ports pio_ports_monitor u_mon (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .hrdata_o(hrdata_o), .pb_pin_i(pb_pin_i), .pb_pins_o(pb_pins_o),
  .card_interface_enable_pin_i(card_interface_enable_pin_i), .pc_pins_o(pc_pins_o), .periph_i(periph_i),
  .timer1_input_o(timer1_input_o), .timer2_input_o(timer2_input_o), .pb_irq_req_o(pb_irq_req_o));

// ===== tb_top.sv
// testbench: register, pin and interrupt scenarios for the parallel port block
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i, nrst_i, hsel, hwrite, hrdy, hresp, card_en, t1, t2, rfsh;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [11:0] pb_ext, pb_lvl;
  logic [7:0] pc_ext, pc_lvl;
  logic [15:0] pd_pin, pa_sel, pa_dir, pa_lat;
  logic [3:0] irq;
  logic [3:0][7:0] irq_cnt;
  pio_pkg::pio_pb_pins_s pb_pins;
  pio_pkg::pio_pc_pins_s pc_pins;
  int err_total, cmp_count, cyc;
  pio_ports DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(pio_pkg::PIO_HSIZE_WORD), .hready_i(hrdy), .hwdata_i(hwdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .pb_pin_i(pb_lvl), .pb_pins_o(pb_pins),
    .card_interface_enable_pin_i(card_en), .pc_pin_i(pc_lvl), .pc_pins_o(pc_pins), .pd_pin_i(pd_pin),
    .periph_i(6'h1B), .refresh_req_i(rfsh), .timer1_input_o(t1), .timer2_input_o(t2),
    .pb_irq_req_o(irq), .port_a_select_bits_o(pa_sel), .port_a_direction_bits_o(pa_dir),
    .port_a_latch_o(pa_lat));
  pio_board u_board (.pb_pins_i(pb_pins), .pc_pins_i(pc_pins), .pb_ext_i(pb_ext), .pc_ext_i(pc_ext),
    .pb_lvl_o(pb_lvl), .pc_lvl_o(pc_lvl));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < 4; i++) irq_cnt[i] <= irq_cnt[i] + 8'(irq[i]);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single transfer; the wait ends only on hready or the bench timeout
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= pio_pkg::PIO_HTRANS_NONSEQ;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic t_reset;
    logic [7:0] a [7] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h28, 8'h2C};
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, a[i], 16'h0000);
      chk(rd, (a[i] == pio_pkg::PIO_B_SEL_ADDR) ? 32'h00000080 : 32'h00000000);
    end
    chk(pb_pins.oe_n, 12'hF7F);
    chk(pc_pins.oe_n, 8'hFF);
    chk({pa_sel, pa_dir}, 32'h00000000);
  endtask
  task automatic t_regs;
    logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h30};
    logic [15:0] e [7] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'h0FFF, 16'h00FF, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, a[i], 16'hFFFF);
      xfer(1'b0, a[i], 16'h0000);
      chk(rd, e[i]);
    end
    // port a copies toward the port a pin logic
    chk({pa_sel, pa_dir}, 32'hFFFFFFFF);
    chk(pa_lat, 16'hFFFF);
    xfer(1'b1, pio_pkg::PIO_D_DAT_ADDR, 16'h0F0F);
    xfer(1'b0, pio_pkg::PIO_D_DAT_ADDR, 16'h0000);
    chk(rd, 32'h00001234);
  endtask
  task automatic t_pb;
    xfer(1'b1, pio_pkg::PIO_B_SEL_ADDR, 16'h0000);
    xfer(1'b1, pio_pkg::PIO_B_DIR_ADDR, 16'h0A0F);
    xfer(1'b1, pio_pkg::PIO_B_DAT_ADDR, 16'h0CC3);
    repeat (2) @(posedge clk_sys_i);
    xfer(1'b0, pio_pkg::PIO_B_DAT_ADDR, 16'h0000);
    chk(rd, 32'h00000DA3);
    chk(pb_pins.oe_n, 12'h5F0);
    chk(pb_pins.out & 12'hA0F, 12'h803);
  endtask
  task automatic t_periph;
    pb_ext <= 12'h5AD;
    xfer(1'b1, pio_pkg::PIO_B_SEL_ADDR, 16'h00FF);
    repeat (3) @(posedge clk_sys_i);
    chk({t1, t2}, 2'b11);
    chk({pb_pins.out[6], pb_pins.out[4], pb_pins.out[2:0], pb_pins.out[7]}, 6'b110110);
    chk(pb_pins.oe_n[7:0], 8'h28);
    xfer(1'b0, pio_pkg::PIO_B_DAT_ADDR, 16'h0000);
    chk(rd, 32'h00000D7B);
    xfer(1'b1, pio_pkg::PIO_B_SEL_ADDR, 16'h0000);
    repeat (3) @(posedge clk_sys_i);
    chk({t1, t2}, 2'b00);
  endtask
  // drop the upper pins together and count the requests that follow
  task automatic drop(input logic [31:0] exp);
    logic [31:0] base;
    base = irq_cnt;
    pb_ext <= 12'h0FF;
    repeat (8) @(posedge clk_sys_i);
    chk(irq_cnt - base, exp);
    pb_ext <= 12'hFFF;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic t_irq;
    pb_ext <= 12'hFFF;
    xfer(1'b1, pio_pkg::PIO_B_DIR_ADDR, 16'h0000);
    xfer(1'b1, pio_pkg::PIO_GLB_MASK_ADDR, 16'h0001);
    xfer(1'b1, pio_pkg::PIO_SRC_MASK_ADDR, 16'h000F);
    repeat (4) @(posedge clk_sys_i);
    drop(32'h01010101);
    xfer(1'b1, pio_pkg::PIO_SRC_MASK_ADDR, 16'h000D);
    drop(32'h01010001);
    xfer(1'b1, pio_pkg::PIO_SYS_CTRL_ADDR, 16'h0001);
    repeat (2) @(posedge clk_sys_i);
    chk({pb_pins.oe_n[8], pb_pins.out[8]}, 2'b01);
    // pin follows the refresh request; its fall must raise no request
    rfsh <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk({pb_pins.oe_n[8], pb_pins.out[8]}, 2'b00);
    drop(32'h01010000);
    xfer(1'b1, pio_pkg::PIO_GLB_MASK_ADDR, 16'h0000);
    drop(32'h00000000);
  endtask
  task automatic t_pcd;
    xfer(1'b1, pio_pkg::PIO_C_DIR_ADDR, 16'h00F0);
    xfer(1'b1, pio_pkg::PIO_C_DAT_ADDR, 16'h005A);
    repeat (2) @(posedge clk_sys_i);
    xfer(1'b0, pio_pkg::PIO_C_DAT_ADDR, 16'h0000);
    chk(rd, 32'h0000005C);
    chk({pc_pins.oe_n, pc_pins.out & 8'hF0}, 16'h0F50);
    pd_pin <= 16'hA55A;
    xfer(1'b0, pio_pkg::PIO_D_DAT_ADDR, 16'h0000);
    chk(rd, 32'h0000A55A);
    card_en <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(pc_pins.oe_n, 8'hFF);
    xfer(1'b0, pio_pkg::PIO_D_DAT_ADDR, 16'h0000);
    chk(rd, 32'h00000000);
  endtask
  initial begin
    nrst_i = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    card_en = 1'b0;
    rfsh = 1'b1;
    pb_ext = 12'h5A5;
    pc_ext = 8'h3C;
    pd_pin = 16'h1234;
    irq_cnt = '0;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    t_reset();
    t_regs();
    t_pb();
    t_periph();
    t_irq();
    t_pcd();
    tally_and_finish();
  end
endmodule
